// ---- bench/microprogram_memory_model.sv ----
`timescale 1ns/1ps
module microprogram_memory_model (
    input wire logic [sequencer_pkg::ADDR_WIDTH-1:0] address,
    output logic [1:sequencer_pkg::MICROWORD_WIDTH] word
);
    import sequencer_pkg::*;
    logic [15:0] store [0:15];
    // =========================================
    // Store
    // Every slot starts as a Type I word so an unused slot never fakes a Type II
    initial begin
        for (int i = 0; i < 16; i++) begin
            store[i] = 16'hF000 | 16'(i);
        end
    end
    // Low address bits only: higher slots alias, so the bench keeps to small images
    assign word = store[address[3:0]];
endmodule // microprogram_memory_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import sequencer_pkg::*;
    logic clk_sys, reset, conditionResult, skipPhase3OnFalse, nanobitShifterLoad;
    logic copyMicrowordToAlternate, shiftAmountLoad, literalLoad, regWrite, regRead;
    logic type2Flag, phase3ClockInhibitN, phaseThree;
    logic [1:16] microword;
    successor_t trueSuccessor, falseSuccessor;
    logic [13:0] barrelShifter, microprogramAddress, microProgramCounter;
    logic [13:0] alternateAddressRegister, ctr, alt, addr;
    logic [1:0] regAddr;
    logic [15:0] regWriteData, regReadData;
    logic [3:0] shiftAmountRegister;
    logic [7:0] literalRegister;
    int failCount, samplesChecked;

    microprogram_address_sequencer i_dut (
        .clk_sys, .reset, .microword, .trueSuccessor, .falseSuccessor,
        .conditionResult, .skipPhase3OnFalse, .nanobitShifterLoad,
        .copyMicrowordToAlternate, .shiftAmountLoad, .literalLoad, .barrelShifter,
        .regAddr, .regWriteData, .regWrite, .regRead, .regReadData,
        .microprogramAddress, .microProgramCounter, .alternateAddressRegister,
        .shiftAmountRegister, .literalRegister, .type2Flag, .phase3ClockInhibitN,
        .phaseThree
    );
    microprogram_memory_model i_mem (
        .address(microprogramAddress),
        .word(microword)
    );

    initial begin
        clk_sys = 1'b0;
        forever begin
            #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
        end
    end

    // =========================================
    // Checking and closing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic endOfTest();
        $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #(CLK_PERIOD_NS * 5000);
        failCount++;
        endOfTest();
    end

    // =========================================
    // Reference for Type I successors
    task automatic model(input successor_t c);
        logic [13:0] m;
        m = ctr;
        case (c)
            SUCC_STEP, SUCC_SAVE: ctr = m + 14'h0001;
            SUCC_SKIP: ctr = m + 14'h0002;
            SUCC_JUMP, SUCC_CALL: ctr = alt + 14'h0001;
            SUCC_RETURN: ctr = alt + 14'h0002;
            default: ;
        endcase
        if (c == SUCC_INDIRECT) addr = alt + 14'h0001;
        else if (c != SUCC_WAIT) addr = ctr;
        if (c == SUCC_SAVE || c == SUCC_CALL) alt = m;
    endtask

    // =========================================
    // Access tasks; instr, regWr and regRd each spend two rising edges so the phase stays aligned
    task automatic setWord(input logic [15:0] w);
        i_mem.store[addr[3:0]] = w;
    endtask
    task automatic instr(input successor_t tc, input successor_t fc, input logic cond,
                         input logic [3:0] f);
        trueSuccessor <= tc;
        falseSuccessor <= fc;
        conditionResult <= cond;
        {skipPhase3OnFalse, nanobitShifterLoad, copyMicrowordToAlternate} <= f[3:1];
        shiftAmountLoad <= f[0];
        literalLoad <= f[0];
        @(posedge clk_sys);
        trueSuccessor <= SUCC_WAIT;
        falseSuccessor <= SUCC_WAIT;
        copyMicrowordToAlternate <= 1'b0;
        shiftAmountLoad <= 1'b0;
        literalLoad <= 1'b0;
        @(negedge clk_sys);
        check(16'(microProgramCounter), 16'(ctr));
        check(16'(microprogramAddress), 16'(addr));
        check(16'(alternateAddressRegister), 16'(alt));
        check(16'(phaseThree), 16'h0001);
        @(posedge clk_sys);
    endtask
    task automatic regWr(input logic [1:0] a, input logic [15:0] d);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic regRd(input logic [1:0] a, input logic [15:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        check(regReadData, exp);
        @(posedge clk_sys);
    endtask

    // =========================================
    // Main sequence
    initial begin
        {reset, conditionResult, skipPhase3OnFalse, nanobitShifterLoad} = 4'hC;
        {copyMicrowordToAlternate, shiftAmountLoad, literalLoad} = 3'h0;
        {regWrite, regRead, regAddr, regWriteData, barrelShifter} = '0;
        trueSuccessor = SUCC_WAIT;
        falseSuccessor = SUCC_WAIT;
        {ctr, alt, addr} = '0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        regRd(REG_CONTROL, 16'(CONTROL_RESET));
        regRd(REG_COUNTER, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            model(successor_t'(i % 8));
            if (i < 8) instr(successor_t'(i), SUCC_SKIP, 1'b1, 4'h0);
            else instr(SUCC_SKIP, successor_t'(i - 8), 1'b0, 4'h0);
        end
        $display("test successor codes done");
        // Target minus one, since the sequencer increments before use
        setWord(16'hF0A9);
        alt = 14'h30A9;
        model(SUCC_STEP);
        instr(SUCC_STEP, SUCC_WAIT, 1'b1, 4'h3);
        check(16'(shiftAmountRegister), 16'h0009);
        check(16'(literalRegister), 16'h00A9);
        model(SUCC_JUMP);
        instr(SUCC_JUMP, SUCC_WAIT, 1'b1, 4'h0);
        model(SUCC_SAVE);
        instr(SUCC_SAVE, SUCC_WAIT, 1'b1, 4'h2);
        $display("test alternate transfers done");
        barrelShifter <= 14'h2A5C;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h4);
        instr(SUCC_WAIT, SUCC_WAIT, 1'b0, 4'h8);
        check(16'(phase3ClockInhibitN), 16'h0000);
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        alt = 14'h2A5C;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        $display("test shifter load done");
        setWord(16'hA000);
        ctr = ctr + 14'h0001;
        addr = ctr;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        check(16'(type2Flag), 16'h0001);
        check(16'(phase3ClockInhibitN), 16'h0000);
        regRd(REG_STATUS, 16'h0001);
        setWord(16'h4013);
        ctr = 14'h0014;
        addr = ctr;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        setWord(16'h0021);
        alt = ctr;
        ctr = 14'h0022;
        addr = ctr;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        $display("test type two done");
        regRd(REG_ALTERNATE, 16'(alt));
        regWr(REG_COUNTER, 16'h1234);
        regRd(REG_COUNTER, 16'(ctr));
        regWr(REG_CONTROL, 16'h0000);
        instr(SUCC_STEP, SUCC_STEP, 1'b1, 4'h0);
        // Force bit is still set at the edge that clears it, so two steps
        regWr(REG_CONTROL, 16'h0003);
        ctr = ctr + 14'h0001;
        addr = ctr;
        instr(SUCC_WAIT, SUCC_WAIT, 1'b1, 4'h0);
        regWr(REG_CONTROL, 16'hFFFD);
        ctr = ctr + 14'h0001;
        regRd(REG_COUNTER, 16'(ctr));
        regRd(REG_CONTROL, 16'h0001);
        $display("test register port done");
        endOfTest();
    end
endmodule // tb_top

// ---- logic/microprogram_address_sequencer.sv ----
`timescale 1ns/1ps
// Functional notes
// RULE_01: Fourteen bit micro program counter
// RULE_02: Counter holds current address, except indirect
// RULE_03: Counter loads only from incrementer select
// RULE_04: Counter loads on strobe with enable
// RULE_05: Counter feeds incrementer and alternate selector
// RULE_06: Fourteen bit alternate address register
// RULE_07: Microcode stores target minus one
// RULE_08: Alternate register usable as temporary storage
// RULE_09: Alternate input: counter, microword, shifter
// RULE_10: Copy transfer loads counter into alternate
// RULE_11: Microword transfer loads bits 3-16
// RULE_12: Alternate strobe gated by transfers, inhibit
// RULE_13: System clock strobes in phases 1, 3
// RULE_14: Phase 3 suppressed: Type II, skipped
// RULE_15: Phase 3 inhibit is active low
// RULE_16: Nanobit 42 loads shifter bits, else hold
// RULE_17: Loads shift amount, literal; makes flags
// RULE_18: Supplies memory address, orders microinstructions
// RULE_19: Successor code chosen by condition result
// RULE_20: Incrementer adds one or two
// RULE_21: Shifter load lands at next Type I phase 3
// RULE_22: Registers hold when no strobe active
module microprogram_address_sequencer #(
    parameter int ADDR_WIDTH = sequencer_pkg::ADDR_WIDTH,
    parameter int SHIFT_WIDTH = sequencer_pkg::SHIFT_AMOUNT_WIDTH,
    parameter int LITERAL_WIDTH = sequencer_pkg::LITERAL_WIDTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:sequencer_pkg::MICROWORD_WIDTH] microword,
    input wire sequencer_pkg::successor_t trueSuccessor,
    input wire sequencer_pkg::successor_t falseSuccessor,
    input wire logic conditionResult,
    input wire logic skipPhase3OnFalse,
    input wire logic nanobitShifterLoad,
    input wire logic copyMicrowordToAlternate,
    input wire logic shiftAmountLoad,
    input wire logic literalLoad,
    input wire logic [ADDR_WIDTH-1:0] barrelShifter,
    input wire logic [sequencer_pkg::REG_ADDR_WIDTH-1:0] regAddr,
    input wire logic [sequencer_pkg::REG_DATA_WIDTH-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [sequencer_pkg::REG_DATA_WIDTH-1:0] regReadData,
    output logic [ADDR_WIDTH-1:0] microprogramAddress,
    output logic [ADDR_WIDTH-1:0] microProgramCounter,
    output logic [ADDR_WIDTH-1:0] alternateAddressRegister,
    output logic [SHIFT_WIDTH-1:0] shiftAmountRegister,
    output logic [LITERAL_WIDTH-1:0] literalRegister,
    output logic type2Flag,
    output logic phase3ClockInhibitN,
    output logic phaseThree
);
    import sequencer_pkg::*;

    // =========================================
    // Phase of the microinstruction cycle
    logic next_phaseThree;

    always_comb begin
        next_phaseThree = ~phaseThree; // RULE_13
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            phaseThree <= 1'b0;
        end else begin
            phaseThree <= next_phaseThree;
        end
    end

    // =========================================
    // Software control
    logic [1:0] control;
    logic [1:0] next_control;
    logic [REG_DATA_WIDTH-1:0] next_regReadData;
    logic runEnable;
    logic forceStep;

    assign runEnable = control[CTRL_RUN_BIT];
    assign forceStep = control[CTRL_FORCE_STEP_BIT];

    // =========================================
    // Microinstruction form and successor choice
    successor_t successorCode;
    logic type2Now;
    logic branchOrCall;
    logic directCall;
    logic [ADDR_WIDTH-1:0] microwordTarget;

    assign successorCode = conditionResult ? trueSuccessor : falseSuccessor; // RULE_19
    // A forced step overrides the microword form, so a stuck routine can be walked
    assign type2Now = (~&microword[1:4]) | forceStep;
    assign branchOrCall = ~microword[1] & ~forceStep;
    assign directCall = branchOrCall & ~microword[2];
    assign microwordTarget = microword[MW_TARGET_FIRST:MICROWORD_WIDTH];

    logic counterLoad;
    logic incrementerLoad;
    inc_source_t incSource;
    logic addTwo;
    logic copyCounter;
    logic [ADDR_WIDTH-1:0] selectOut;

    successor_decoder decoder (
        .code(successorCode),
        .type2(type2Now),
        .branchOrCall(branchOrCall),
        .directCall(directCall),
        .counterLoad(counterLoad),
        .incrementerLoad(incrementerLoad),
        .source(incSource),
        .addTwo(addTwo),
        .copyCounter(copyCounter)
    );

    next_address_incrementer #(
        .WIDTH(ADDR_WIDTH)
    ) incrementer (
        .counterValue(microProgramCounter), // RULE_05
        .alternateValue(alternateAddressRegister),
        .microwordValue(microwordTarget),
        .source(incSource),
        .addTwo(addTwo), // RULE_20
        .sum(selectOut)
    );

    // =========================================
    // Strobes, gated copies of the system clock
    logic sequenceStrobe;
    logic counterStrobe;
    logic incrementerStrobe;
    logic copyCounterStrobe;
    logic copyMicrowordStrobe;
    logic shifterStrobe;
    logic alternateStrobe;
    // Pending shifter load, carried from one microinstruction into the next
    logic shifterToAlternateSelect;

    // Sequencing registers move at the phase 1 edge, shifter data at phase 3
    assign sequenceStrobe = ~phaseThree & runEnable;
    assign counterStrobe = sequenceStrobe & counterLoad; // RULE_04
    assign incrementerStrobe = sequenceStrobe & incrementerLoad;
    assign copyCounterStrobe = sequenceStrobe & copyCounter;
    assign copyMicrowordStrobe = sequenceStrobe & copyMicrowordToAlternate;
    assign shifterStrobe = phaseThree & runEnable & phase3ClockInhibitN
        & shifterToAlternateSelect; // RULE_21
    assign alternateStrobe = copyCounterStrobe | copyMicrowordStrobe
        | shifterStrobe; // RULE_12

    // =========================================
    // Address registers
    logic next_shifterToAlternateSelect;
    logic [ADDR_WIDTH-1:0] next_microProgramCounter;
    logic [ADDR_WIDTH-1:0] next_alternateAddressRegister;
    logic [ADDR_WIDTH-1:0] next_microprogramAddress;

    always_comb begin
        next_microProgramCounter = microProgramCounter; // RULE_22
        next_microprogramAddress = microprogramAddress;
        next_alternateAddressRegister = alternateAddressRegister;
        next_shifterToAlternateSelect = shifterToAlternateSelect;
        if (counterStrobe) begin
            // Indirect run leaves the counter on the current address
            next_microProgramCounter = selectOut; // RULE_01 RULE_02 RULE_03
        end
        if (incrementerStrobe) begin
            next_microprogramAddress = selectOut; // RULE_18
        end
        // Three-way input selector; a copy outranks a pending shifter load
        if (copyCounterStrobe) begin
            next_alternateAddressRegister = microProgramCounter; // RULE_06 RULE_09 RULE_10
        end else if (copyMicrowordStrobe) begin
            next_alternateAddressRegister = microwordTarget; // RULE_08 RULE_11
        end else if (shifterStrobe) begin
            next_alternateAddressRegister = barrelShifter; // RULE_16
        end
        // Shifter request is taken at the end of one microinstruction and
        // consumed by the phase 3 of the next one that is not inhibited
        if (phaseThree & runEnable) begin
            if (phase3ClockInhibitN) begin
                next_shifterToAlternateSelect = nanobitShifterLoad; // RULE_16 RULE_21
            end else begin
                next_shifterToAlternateSelect = shifterToAlternateSelect | nanobitShifterLoad;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            microProgramCounter <= COUNTER_RESET;
            microprogramAddress <= INCREMENTER_RESET;
            alternateAddressRegister <= ALTERNATE_RESET;
            shifterToAlternateSelect <= 1'b0;
        end else begin
            microProgramCounter <= next_microProgramCounter;
            microprogramAddress <= next_microprogramAddress;
            alternateAddressRegister <= next_alternateAddressRegister;
            shifterToAlternateSelect <= next_shifterToAlternateSelect;
        end
    end

    // =========================================
    // Type II flag and phase 3 inhibit
    logic next_type2Flag;
    logic next_phase3ClockInhibitN;

    always_comb begin
        next_type2Flag = type2Flag;
        next_phase3ClockInhibitN = phase3ClockInhibitN;
        if (sequenceStrobe) begin
            next_type2Flag = type2Now; // RULE_17
            // Low blocks phase 3 of this microinstruction
            next_phase3ClockInhibitN = ~(type2Now
                | (~conditionResult & skipPhase3OnFalse)); // RULE_14 RULE_15
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            type2Flag <= 1'b0;
            phase3ClockInhibitN <= 1'b1;
        end else begin
            type2Flag <= next_type2Flag;
            phase3ClockInhibitN <= next_phase3ClockInhibitN;
        end
    end

    // =========================================
    // Shift amount and literal from the microword
    logic [SHIFT_WIDTH-1:0] next_shiftAmountRegister;
    logic [LITERAL_WIDTH-1:0] next_literalRegister;

    always_comb begin
        next_shiftAmountRegister = shiftAmountRegister;
        next_literalRegister = literalRegister;
        if (sequenceStrobe & shiftAmountLoad) begin
            next_shiftAmountRegister =
                microword[SHIFT_FIELD_FIRST:MICROWORD_WIDTH]; // RULE_17
        end
        if (sequenceStrobe & literalLoad) begin
            next_literalRegister = microword[LITERAL_FIELD_FIRST:MICROWORD_WIDTH]; // RULE_17
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shiftAmountRegister <= '0;
            literalRegister <= '0;
        end else begin
            shiftAmountRegister <= next_shiftAmountRegister;
            literalRegister <= next_literalRegister;
        end
    end

    // =========================================
    // Register port: read data valid the cycle after the strobe
    always_comb begin
        next_control = control;
        next_regReadData = '0;
        if (regWrite && regAddr == REG_CONTROL) begin
            next_control = regWriteData[1:0];
        end
        if (regRead) begin
            if (regAddr == REG_CONTROL) begin
                next_regReadData = {14'h0000, control};
            end else if (regAddr == REG_COUNTER) begin
                next_regReadData = {2'h0, microProgramCounter};
            end else if (regAddr == REG_ALTERNATE) begin
                next_regReadData = {2'h0, alternateAddressRegister};
            end else begin
                next_regReadData = {12'h000, shifterToAlternateSelect, phaseThree,
                    phase3ClockInhibitN, type2Flag};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            control <= CONTROL_RESET;
            regReadData <= '0;
        end else begin
            control <= next_control;
            regReadData <= next_regReadData;
        end
    end

    // =========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic plainStep;
    assign plainStep = sequenceStrobe & ~type2Now;

    AST_PHASE_ALTERNATES: assert property ( // RULE_13
        phaseThree |=> !phaseThree ##1 phaseThree)
        else $error("phase did not alternate");

    AST_COUNTER_FROM_SELECT: assert property ( // RULE_03
        !$stable(microProgramCounter) |-> microProgramCounter == $past(selectOut))
        else $error("counter loaded from wrong source");

    AST_COUNTER_ONLY_PHASE1: assert property ( // RULE_04
        (phaseThree || !counterLoad || !runEnable) |=> $stable(microProgramCounter))
        else $error("counter moved without strobe");

    AST_WAIT_HOLDS: assert property ( // RULE_22
        plainStep && successorCode == SUCC_WAIT
        |=> $stable(microProgramCounter) && $stable(microprogramAddress))
        else $error("wait changed an address register");

    AST_SKIP_ADDS_TWO: assert property ( // RULE_20
        plainStep && successorCode == SUCC_SKIP
        |=> microProgramCounter == $past(microProgramCounter) + 14'h0002)
        else $error("skip did not add two");

    AST_RETURN_TARGET: assert property ( // RULE_19
        plainStep && successorCode == SUCC_RETURN
        |=> microprogramAddress == $past(alternateAddressRegister) + 14'h0002)
        else $error("return address wrong");

    AST_INDIRECT_KEEPS_COUNTER: assert property ( // RULE_02
        plainStep && successorCode == SUCC_INDIRECT
        |=> $stable(microProgramCounter)
        && microprogramAddress == $past(alternateAddressRegister) + 14'h0001)
        else $error("indirect run mishandled counter");

    AST_COPY_COUNTER: assert property ( // RULE_10
        copyCounterStrobe |=> alternateAddressRegister == $past(microProgramCounter))
        else $error("alternate missed counter copy");

    AST_TYPE2_INHIBITS: assert property ( // RULE_14
        sequenceStrobe && type2Now |=> !phase3ClockInhibitN && type2Flag)
        else $error("type II did not inhibit phase 3");

    AST_SHIFTER_LOAD: assert property ( // RULE_21
        shifterStrobe && !copyCounterStrobe
        |=> alternateAddressRegister == $past(barrelShifter))
        else $error("shifter load lost");

    AST_INHIBIT_BLOCKS_SHIFTER: assert property ( // RULE_15
        phaseThree && !phase3ClockInhibitN |=> $stable(alternateAddressRegister))
        else $error("alternate loaded while inhibited");

    COV_CALL: cover property (plainStep && successorCode == SUCC_CALL);
    COV_TYPE2_CALL: cover property (sequenceStrobe && type2Now && directCall);
    COV_SHIFTER: cover property (shifterStrobe);
    COV_SKIPPED_PHASE3: cover property (
        sequenceStrobe && !type2Now && !conditionResult && skipPhase3OnFalse);

endmodule // microprogram_address_sequencer

// ---- logic/next_address_incrementer.sv ----
`timescale 1ns/1ps
module next_address_incrementer #(
    parameter int WIDTH = sequencer_pkg::ADDR_WIDTH
) (
    input wire logic [WIDTH-1:0] counterValue,
    input wire logic [WIDTH-1:0] alternateValue,
    input wire logic [WIDTH-1:0] microwordValue,
    input wire sequencer_pkg::inc_source_t source,
    input wire logic addTwo,
    output logic [WIDTH-1:0] sum
);
    import sequencer_pkg::*;
    logic [WIDTH-1:0] operand;
    always_comb begin
        if (source == SRC_ALTERNATE) begin
            operand = alternateValue;
        end else if (source == SRC_MICROWORD) begin
            operand = microwordValue;
        end else begin
            operand = counterValue;
        end
        // Wraps at the top of the address space
        sum = operand + (addTwo ? WIDTH'(2) : WIDTH'(1));
    end
endmodule // next_address_incrementer

// ---- logic/sequencer_pkg.sv ----
package sequencer_pkg;
    // =========================================
    // Widths
    localparam int ADDR_WIDTH = 14;
    localparam int MICROWORD_WIDTH = 16;
    localparam int SHIFT_AMOUNT_WIDTH = 4;
    localparam int LITERAL_WIDTH = 8;
    localparam int REG_ADDR_WIDTH = 2;
    localparam int REG_DATA_WIDTH = 16;
    localparam int CLK_PERIOD_NS = 100;
    // =========================================
    // Microword field positions, bit 1 is the leftmost bit
    localparam int MW_TARGET_FIRST = 3;
    localparam int SHIFT_FIELD_FIRST = 13;
    localparam int LITERAL_FIELD_FIRST = 9;
    // =========================================
    // Register port map
    localparam logic [1:0] REG_CONTROL = 2'h0;
    localparam logic [1:0] REG_COUNTER = 2'h1;
    localparam logic [1:0] REG_ALTERNATE = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_FORCE_STEP_BIT = 1;
    localparam int STAT_TYPE2_BIT = 0;
    localparam int STAT_INHIBIT_N_BIT = 1;
    localparam int STAT_PHASE3_BIT = 2;
    localparam int STAT_PENDING_BIT = 3;
    // =========================================
    // Reset values
    localparam logic [1:0] CONTROL_RESET = 2'h1;
    localparam logic [13:0] COUNTER_RESET = 14'h0000;
    localparam logic [13:0] ALTERNATE_RESET = 14'h0000;
    localparam logic [13:0] INCREMENTER_RESET = 14'h0000;
    // =========================================
    // Types
    typedef enum logic [2:0] {
        SUCC_WAIT, SUCC_STEP, SUCC_SAVE, SUCC_SKIP,
        SUCC_INDIRECT, SUCC_JUMP, SUCC_CALL, SUCC_RETURN
    } successor_t;
    typedef enum logic [1:0] {SRC_COUNTER, SRC_ALTERNATE, SRC_MICROWORD} inc_source_t;
endpackage

// ---- logic/successor_decoder.sv ----
`timescale 1ns/1ps
module successor_decoder (
    input wire sequencer_pkg::successor_t code,
    input wire logic type2,
    input wire logic branchOrCall,
    input wire logic directCall,
    output logic counterLoad,
    output logic incrementerLoad,
    output sequencer_pkg::inc_source_t source,
    output logic addTwo,
    output logic copyCounter
);
    import sequencer_pkg::*;
    always_comb begin
        counterLoad = 1'b1;
        incrementerLoad = 1'b1;
        source = SRC_COUNTER;
        addTwo = 1'b0;
        copyCounter = 1'b0;
        if (type2) begin
            // Second form: step, or branch/call to the microword target
            if (branchOrCall) begin
                source = SRC_MICROWORD;
            end
            copyCounter = directCall;
        end else begin
            case (code)
                SUCC_WAIT: begin
                    counterLoad = 1'b0;
                    incrementerLoad = 1'b0;
                end
                SUCC_STEP: ;
                SUCC_SAVE: copyCounter = 1'b1;
                SUCC_SKIP: addTwo = 1'b1;
                SUCC_INDIRECT: begin
                    counterLoad = 1'b0;
                    source = SRC_ALTERNATE;
                end
                SUCC_JUMP: source = SRC_ALTERNATE;
                SUCC_CALL: begin
                    source = SRC_ALTERNATE;
                    copyCounter = 1'b1;
                end
                default: begin
                    source = SRC_ALTERNATE;
                    addTwo = 1'b1;
                end
            endcase
        end
    end
endmodule // successor_decoder
